// ==== programmable_function_unit.sv ====
// four-slice programmable function unit with an APB configuration port
// assumes fabric inputs are synchronous to clk; slice_clk is a sampled
// fabric signal, not a real clock, so edges are seen at clk resolution
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module programmable_function_unit #(
   parameter bit HAS_RAM = 1'b1
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [3:0][3:0]           table_a,
   input  wire logic [3:0][3:0]           table_b,
   input  wire logic [3:0]                sel5,
   input  wire logic [3:0][1:0]           data_in,
   input  wire logic [3:0]                ram_we,
   input  wire logic [3:0]                slice_clk,
   input  wire logic [3:0]                slice_ce,
   input  wire logic [3:0]                slice_lsr,
   input  wire logic [3:0]                sub_ctl,
   input  wire logic                      carry_in,
   input  wire logic [1:0]                sel6,
   input  wire logic                      sel7,
   output logic      [3:0][1:0]           q,
   output logic      [3:0][1:0]           f,
   output logic      [3:0]                f5,
   output logic      [3:0]                carry_gen,
   output logic      [3:0]                carry_prop,
   output logic                           carry_out,
   output logic      [1:0]                f6,
   output logic                           f7
);

   localparam int N = slice_pkg::SLICES;

   // configuration state
   logic [N-1:0][slice_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic                                user_r, user_nxt;
   logic                                pready_r, pready_nxt;
   logic                                pslverr_r, pslverr_nxt;
   logic [31:0]                         prdata_r, prdata_nxt;

   // datapath state
   logic [N-1:0]                        sclk_prev_r, sclk_prev_nxt;
   logic [N-1:0][1:0]                   f_r, f_nxt;
   logic [N-1:0]                        f5_r, f5_nxt;
   logic [N-1:0]                        gen_r, gen_nxt;
   logic [N-1:0]                        prop_r, prop_nxt;
   logic                                cout_r, cout_nxt;
   logic [1:0]                          f6_r, f6_nxt;
   logic                                f7_r, f7_nxt;

   // per-slice wires
   logic [N-1:0][1:0]                   rd_data;
   logic [N-1:0][1:0]                   st_d;
   logic [N-1:0][1:0]                   st_q;
   logic [N-1:0][slice_pkg::TABLE_W-1:0] tab0, tab1;
   logic [N-1:0][1:0]                   cfg_we;
   logic [N-1:0]                        wr_en;
   logic [N-1:0][3:0]                   wr_addr;
   logic [N-1:0][1:0]                   wr_data;
   logic [N-1:0][3:0]                   rd_addr1;
   logic [N-1:0]                        act_level, act_edge;
   logic [N:0]                          chain;

   // bus decode
   logic                                acc, done, in_slice, err;
   logic [1:0]                          sidx;
   logic [3:0]                          ofs;
   logic [31:0]                         rdata;

   function automatic slice_pkg::mode_t mode_of(
         input logic [slice_pkg::CTRL_W-1:0] c);
      mode_of = slice_pkg::mode_t'(c[slice_pkg::CTRL_MODE_LSB +: 2]);
   endfunction

   // ---------------- APB slave and configuration ----------------
   always_comb begin
      acc      = psel && penable;
      done     = acc && pready_r;
      sidx     = paddr[5:4];
      ofs      = paddr[3:0];
      in_slice = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0);
      ctrl_nxt = ctrl_r;
      user_nxt = user_r;
      cfg_we   = '0;
      rdata    = '0;
      err      = 1'b0;
      if (paddr == slice_pkg::ADDR_USER) begin
         rdata = {31'h0, user_r};
      end else if (!in_slice) begin
         err = 1'b1;
      end else begin
         case (ofs)
            slice_pkg::OFS_CTRL: begin
               rdata = {20'h0, ctrl_r[sidx]};
               // the unit without ram refuses ram mode
               if (pwrite && !HAS_RAM
                   && pwdata[slice_pkg::CTRL_MODE_LSB +: 2]
                      == slice_pkg::MODE_RAM) begin
                  err = 1'b1;
               end
            end
            slice_pkg::OFS_TABLE0: begin
               rdata = {16'h0, tab0[sidx]};
               err   = pwrite && user_r;
            end
            slice_pkg::OFS_TABLE1: begin
               rdata = {16'h0, tab1[sidx]};
               err   = pwrite && user_r;
            end
            slice_pkg::OFS_STATUS: begin
               rdata = {24'h0, cout_r, prop_r[sidx], gen_r[sidx],
                        f5_r[sidx], f_r[sidx], st_q[sidx]};
               err   = pwrite;
            end
            default: begin
               err = 1'b1;
            end
         endcase
      end
      if (done && pwrite && !err) begin
         if (paddr == slice_pkg::ADDR_USER) begin
            user_nxt = pwdata[0];
         end else if (ofs == slice_pkg::OFS_CTRL) begin
            ctrl_nxt[sidx] = pwdata[slice_pkg::CTRL_W-1:0];
         end else if (ofs == slice_pkg::OFS_TABLE0) begin
            cfg_we[sidx][0] = 1'b1;
         end else if (ofs == slice_pkg::OFS_TABLE1) begin
            cfg_we[sidx][1] = 1'b1;
         end
      end
      // answer one cycle into the access phase
      pready_nxt  = acc && !pready_r;
      prdata_nxt  = (pready_nxt && !pwrite) ? rdata : 32'h0;
      pslverr_nxt = pready_nxt && err;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r    <= {N{slice_pkg::CTRL_RESET}};
         user_r    <= 1'b0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end else if (ce) begin
         ctrl_r    <= ctrl_nxt;
         user_r    <= user_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   // ---------------- slice datapath ----------------
   always_comb begin
      logic [1:0]  a, b, x, y, r;
      logic [2:0]  s;
      logic        cmp, cin;
      slice_pkg::mode_t mode;
      slice_pkg::op_t   op;
      a = '0;
      b = '0;
      x = '0;
      y = '0;
      r = '0;
      s = '0;
      cmp = 1'b0;
      cin = 1'b0;
      mode = slice_pkg::MODE_LOGIC;
      op = slice_pkg::OP_ADD;
      chain[0]      = carry_in;
      sclk_prev_nxt = slice_clk;
      for (int k = 0; k < N; k++) begin
         mode = mode_of(ctrl_r[k]);
         op   = slice_pkg::op_t'(ctrl_r[k][slice_pkg::CTRL_OP_LSB +: 4]);
         a    = table_a[k][1:0];
         b    = table_b[k][1:0];
         cin  = chain[k];
         act_level[k] = slice_clk[k] ^ ctrl_r[k][slice_pkg::CTRL_NEG];
         act_edge[k]  = act_level[k]
                        && !(sclk_prev_r[k]
                             ^ ctrl_r[k][slice_pkg::CTRL_NEG]);
         // operands for the shared 2-bit adder
         case (op)
            slice_pkg::OP_SUB: begin
               x = a;
               y = ~b;
            end
            slice_pkg::OP_ADDSUB: begin
               x = a;
               y = sub_ctl[k] ? ~b : b;
            end
            slice_pkg::OP_UP: begin
               x = st_q[k];
               y = 2'h0;
            end
            slice_pkg::OP_DOWN: begin
               x = st_q[k];
               y = {2{cin}};
            end
            slice_pkg::OP_MULT: begin
               x = st_q[k];
               y = a & {2{b[0]}};
            end
            default: begin
               x = a;
               y = b;
            end
         endcase
         s = slice_pkg::add2(x, y,
                             (op == slice_pkg::OP_DOWN) ? 1'b0 : cin);
         case (op)
            slice_pkg::OP_GE: cmp = (a >= b);
            slice_pkg::OP_NE: cmp = (a != b);
            slice_pkg::OP_LE: cmp = (a <= b);
            default:          cmp = 1'b0;
         endcase
         if (op == slice_pkg::OP_GE || op == slice_pkg::OP_NE
             || op == slice_pkg::OP_LE) begin
            r = {1'b0, cmp};
            chain[k+1] = cin;
         end else if (op == slice_pkg::OP_DOWN) begin
            // down counting chains a borrow, not a carry
            r = s[1:0];
            chain[k+1] = cin && (st_q[k] == 2'h0);
         end else begin
            r = s[1:0];
            chain[k+1] = s[2];
         end
         gen_nxt[k]  = slice_pkg::add2(x, y, 1'b0) > 3'h3;
         prop_nxt[k] = &(x ^ y);
         // memory write port and read addresses
         wr_en[k]    = (mode == slice_pkg::MODE_RAM) && ram_we[k]
                       && act_edge[k] && user_r;
         wr_addr[k]  = table_a[k];
         wr_data[k]  = data_in[k];
         rd_addr1[k] = (mode == slice_pkg::MODE_RAM) ? table_a[k]
                                                     : table_b[k];
         if (mode == slice_pkg::MODE_RIPPLE) begin
            f_nxt[k] = r;
            st_d[k]  = r;
         end else begin
            f_nxt[k] = rd_data[k];
            st_d[k]  = rd_data[k];
         end
         f5_nxt[k] = sel5[k] ? rd_data[k][1] : rd_data[k][0];
      end
      // a companion slice mirrors its partner's writes
      for (int k = 1; k < N; k += 2) begin
         if (ctrl_r[k][slice_pkg::CTRL_DUAL]) begin
            wr_en[k]   = wr_en[k-1];
            wr_addr[k] = wr_addr[k-1];
            wr_data[k] = wr_data[k-1];
         end
      end
      cout_nxt = chain[N];
      for (int j = 0; j < N/2; j++) begin
         f6_nxt[j] = sel6[j] ? f5_nxt[2*j+1] : f5_nxt[2*j];
      end
      f7_nxt = sel7 ? f6_nxt[1] : f6_nxt[0];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_prev_r <= '0;
         f_r         <= '0;
         f5_r        <= '0;
         gen_r       <= '0;
         prop_r      <= '0;
         cout_r      <= 1'b0;
         f6_r        <= '0;
         f7_r        <= 1'b0;
      end else if (ce) begin
         sclk_prev_r <= sclk_prev_nxt;
         f_r         <= f_nxt;
         f5_r        <= f5_nxt;
         gen_r       <= gen_nxt;
         prop_r      <= prop_nxt;
         cout_r      <= cout_nxt;
         f6_r        <= f6_nxt;
         f7_r        <= f7_nxt;
      end
   end

   // ---------------- slices 0 to 3 ----------------
   for (genvar k = 0; k < N; k++) begin : g_slice
      slice_table_memory i_slice_table_memory (
         .clk      (clk),
         .rst      (rst),
         .ce       (ce),
         .cfg_we   (cfg_we[k]),
         .cfg_data (pwdata[slice_pkg::TABLE_W-1:0]),
         .wr_en    (wr_en[k]),
         .wr_addr  (wr_addr[k]),
         .wr_data  (wr_data[k]),
         .rd_addr0 (table_a[k]),
         .rd_addr1 (rd_addr1[k]),
         .rd_data  (rd_data[k]),
         .table0   (tab0[k]),
         .table1   (tab1[k])
      );
      slice_storage #(.WIDTH(2)) i_slice_storage (
         .clk        (clk),
         .rst        (rst),
         .ce         (ce),
         .user_mode  (user_r),
         .latch_mode (ctrl_r[k][slice_pkg::CTRL_LATCH]),
         .async_sr   (ctrl_r[k][slice_pkg::CTRL_ASYNC]),
         .init_val   (ctrl_r[k][slice_pkg::CTRL_INIT_LSB +: 2]),
         .act_level  (act_level[k]),
         .act_edge   (act_edge[k]),
         .elem_ce    (slice_ce[k]),
         .lsr        (slice_lsr[k]),
         .d          (st_d[k]),
         .q          (st_q[k])
      );
   end

   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign q          = st_q;
   assign f          = f_r;
   assign f5         = f5_r;
   assign carry_gen  = gen_r;
   assign carry_prop = prop_r;
   assign carry_out  = cout_r;
   assign f6         = f6_r;
   assign f7         = f7_r;

endmodule // programmable_function_unit

// ==== slice_pkg.sv ====
// shared constants for the programmable function unit and its slices
// assumes a single 100 MHz clock and an APB register port with 32-bit data
package slice_pkg;

   localparam int SLICES     = 4;
   localparam int TABLE_W    = 16;
   localparam int TADDR_W    = 4;
   localparam int APB_AW     = 8;
   localparam int APB_DW     = 32;

   // slice modes, gray ordered logic -> ripple -> rom -> ram
   typedef enum logic [1:0] {
      MODE_LOGIC  = 2'h0,
      MODE_RIPPLE = 2'h1,
      MODE_ROM    = 2'h3,
      MODE_RAM    = 2'h2
   } mode_t;

   typedef enum logic [3:0] {
      OP_ADD    = 4'h0,
      OP_SUB    = 4'h1,
      OP_ADDSUB = 4'h2,
      OP_UP     = 4'h3,
      OP_DOWN   = 4'h4,
      OP_MULT   = 4'h5,
      OP_GE     = 4'h6,
      OP_NE     = 4'h7,
      OP_LE     = 4'h8
   } op_t;

   // register map: one 16-byte window per slice, then the global register
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_TABLE0 = 4'h4;
   localparam logic [3:0] OFS_TABLE1 = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;
   localparam logic [7:0] ADDR_USER  = 8'h40;

   // control register fields
   localparam int CTRL_W        = 12;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_LATCH    = 2;
   localparam int CTRL_NEG      = 3;
   localparam int CTRL_ASYNC    = 4;
   localparam int CTRL_INIT_LSB = 5;
   localparam int CTRL_OP_LSB   = 7;
   localparam int CTRL_DUAL     = 11;

   localparam logic [CTRL_W-1:0]  CTRL_RESET  = 12'h000;
   localparam logic [TABLE_W-1:0] TABLE_RESET = 16'h0000;

   // 2-bit add with carry in, carry out in bit 2
   function automatic logic [2:0] add2(input logic [1:0] x,
                                       input logic [1:0] y,
                                       input logic       c);
      add2 = {1'b0, x} + {1'b0, y} + {2'h0, c};
   endfunction

endpackage

// ==== slice_table_memory.sv ====
// two 16-entry truth tables of one slice, usable as a 16x2 memory
// assumes config writes arrive only outside user mode and writes are
// already qualified by the active slice clock edge
`timescale 1ns/100ps
module slice_table_memory (
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic                          ce,
   input  wire logic [1:0]                    cfg_we,
   input  wire logic [slice_pkg::TABLE_W-1:0] cfg_data,
   input  wire logic                          wr_en,
   input  wire logic [slice_pkg::TADDR_W-1:0] wr_addr,
   input  wire logic [1:0]                    wr_data,
   input  wire logic [slice_pkg::TADDR_W-1:0] rd_addr0,
   input  wire logic [slice_pkg::TADDR_W-1:0] rd_addr1,
   output logic      [1:0]                    rd_data,
   output logic      [slice_pkg::TABLE_W-1:0] table0,
   output logic      [slice_pkg::TABLE_W-1:0] table1
);

   logic [slice_pkg::TABLE_W-1:0] table0_r, table0_nxt;
   logic [slice_pkg::TABLE_W-1:0] table1_r, table1_nxt;

   always_comb begin
      table0_nxt = table0_r;
      table1_nxt = table1_r;
      if (cfg_we[0]) begin
         table0_nxt = cfg_data;
      end
      if (cfg_we[1]) begin
         table1_nxt = cfg_data;
      end
      if (wr_en) begin
         table0_nxt[wr_addr] = wr_data[0];
         table1_nxt[wr_addr] = wr_data[1];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         table0_r <= slice_pkg::TABLE_RESET;
         table1_r <= slice_pkg::TABLE_RESET;
      end else if (ce) begin
         table0_r <= table0_nxt;
         table1_r <= table1_nxt;
      end
   end

   // reads are combinational from the address, indexing the truth table
   assign rd_data = {table1_r[rd_addr1], table0_r[rd_addr0]};
   assign table0  = table0_r;
   assign table1  = table1_r;

endmodule // slice_table_memory

// ==== slice_storage.sv ====
// the storage elements of one slice, each an edge flip-flop or a latch
// assumes the slice clock edge and level are decoded by the caller
`timescale 1ns/100ps
module slice_storage #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             user_mode,
   input  wire logic             latch_mode,
   input  wire logic             async_sr,
   input  wire logic [WIDTH-1:0] init_val,
   input  wire logic             act_level,
   input  wire logic             act_edge,
   input  wire logic             elem_ce,
   input  wire logic             lsr,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] q_r, q_nxt;
   logic             capture;

   always_comb begin
      // a latch follows d for the whole active level
      capture = latch_mode ? act_level : act_edge;
      q_nxt   = q_r;
      if (!user_mode) begin
         q_nxt = init_val;
      end else if (lsr && (async_sr || capture)) begin
         q_nxt = init_val;
      end else if (capture && elem_ce) begin
         q_nxt = d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q_r <= '0;
      end else if (ce) begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;

endmodule // slice_storage

// ==== function_unit_checker.sv ====
// port-level properties of the programmable function unit
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/100ps
module function_unit_checker (
   input wire logic            clk,
   input wire logic            rst,
   input wire logic            ce,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic [31:0]     prdata,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire logic [3:0]      slice_ce,
   input wire logic [3:0]      slice_lsr,
   input wire logic [1:0]      sel6,
   input wire logic            sel7,
   input wire logic [3:0][1:0] q,
   input wire logic [3:0][1:0] f,
   input wire logic [3:0]      f5,
   input wire logic [1:0]      f6,
   input wire logic            f7
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   AST_RESET_CLEARS: assert property (
      $fell(rst) |-> (q == '0 && f == '0 && f5 == '0 && !pready))
      else $error("outputs not cleared by reset");
   AST_WIDE_MUX6: assert property (
      !$past(rst) && $past(ce) |-> f6 == {$past(sel6[1]) ? f5[3] : f5[2],
                                          $past(sel6[0]) ? f5[1] : f5[0]})
      else $error("six-input mux mismatch");
   AST_WIDE_MUX7: assert property (
      !$past(rst) && $past(ce) |-> f7 == ($past(sel7) ? f6[1] : f6[0]))
      else $error("seven-input mux mismatch");
   // storage only moves on enable, set/reset or a configuration write
   AST_STORAGE_HOLDS: assert property (
      !$past(rst) && $past(slice_ce) == 4'h0 && $past(slice_lsr) == 4'h0
      && !$past(psel) && !$past(psel, 2) |-> $stable(q))
      else $error("storage changed without cause");
   AST_CFG_ANSWER: assert property (
      psel && penable && !pready && ce |=> pready)
      else $error("configuration access not answered");
   AST_CFG_PULSE: assert property (
      pready && ce |=> !pready)
      else $error("ready longer than one cycle");
   AST_CFG_ONLY_IN_ACCESS: assert property (
      pready |-> psel && penable)
      else $error("ready outside an access");
   AST_ERR_WITH_READY: assert property (
      pslverr |-> pready)
      else $error("error without ready");
   AST_RDATA_IDLE: assert property (
      !pready |-> prdata == '0)
      else $error("read data outside answer");
endmodule // function_unit_checker

bind programmable_function_unit function_unit_checker i_function_unit_checker (
   .clk, .rst, .ce, .psel, .penable, .prdata, .pready, .pslverr, .slice_ce,
   .slice_lsr, .sel6, .sel7, .q, .f, .f5, .f6, .f7);

// ==== fabric_clock_source.sv ====
// neighbouring fabric driving the slice clocks
// assumes pulse requests are held high for as many edges as wanted
`timescale 1ns/100ps
module fabric_clock_source (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [3:0] pulse,
   output logic      [3:0] slice_clk
);
   logic [3:0] slice_clk_r;
   logic [3:0] slice_clk_nxt;
   // stands still low between requests, so no stray slice edges
   always_comb begin
      slice_clk_nxt = pulse & ~slice_clk_r;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         slice_clk_r <= 4'h0;
      end else begin
         slice_clk_r <= slice_clk_nxt;
      end
   end
   assign slice_clk = slice_clk_r;
endmodule // fabric_clock_source

// ==== programmable_function_unit_bench.sv ====
// self-checking bench for the programmable function unit
// assumes the checker and the fabric clock source are compiled first
`timescale 1ns/100ps
`define CHECK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
   failures++; $display("ERROR %s expected %h seen %h", what, exp, got); end end
module programmable_function_unit_bench;
   logic            clk, rst, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, rd;
   logic [3:0][3:0] table_a, table_b;
   logic [3:0][1:0] data_in, q, f;
   logic [3:0]      sel5, ram_we, slice_clk, slice_ce, slice_lsr, sub_ctl;
   logic [3:0]      f5, carry_gen, carry_prop, pulse, a;
   logic [1:0]      sel6, f6, x, y;
   logic            carry_in, sel7, carry_out, f7, c;
   logic [15:0]     t0 [4], t1 [4], r16;
   int              seed, failures, tests_run, k, i;
   slice_pkg::op_t  ops [6];

   programmable_function_unit i_programmable_function_unit (.clk, .rst, .ce,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .table_a, .table_b, .sel5, .data_in, .ram_we, .slice_clk, .slice_ce,
      .slice_lsr, .sub_ctl, .carry_in, .sel6, .sel7, .q, .f, .f5, .carry_gen,
      .carry_prop, .carry_out, .f6, .f7);
   fabric_clock_source i_fabric_clock_source (.clk, .rst, .pulse, .slice_clk);

   function automatic logic [7:0] ra(int s, logic [3:0] o);
      ra = 8'(s * 16) | 8'(o);
   endfunction
   function automatic logic [1:0] lut(int s, logic [3:0] ad);
      lut = {t1[s][ad], t0[s][ad]};
   endfunction
   function automatic logic [1:0] rip(slice_pkg::op_t op, logic [1:0] u,
                                      logic [1:0] v, logic c);
      case (op)
         slice_pkg::OP_SUB: rip = u - v - {1'b0, !c};
         slice_pkg::OP_ADDSUB: rip = sub_ctl[0] ? u - v - {1'b0, !c}
                                                : u + v + {1'b0, c};
         slice_pkg::OP_GE: rip = {1'b0, u >= v};
         slice_pkg::OP_NE: rip = {1'b0, u != v};
         slice_pkg::OP_LE: rip = {1'b0, u <= v};
         default: rip = u + v + {1'b0, c};
      endcase
   endfunction

   task automatic apb(input logic wr, input logic [7:0] ad,
                      input logic [31:0] wd, input logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      `CHECK("pslverr", err, pslverr)
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      stop_test();
   end

   initial begin
      seed = 68261;
      failures = 0;
      tests_run = 0;
      {rst, ce, psel, penable, pwrite, paddr, pwdata} = {2'b11, 43'h0};
      {table_a, table_b, sel5, data_in, ram_we, slice_ce} = '0;
      {slice_lsr, sub_ctl, carry_in, sel6, sel7, pulse} = '0;
      ops = '{slice_pkg::OP_ADD, slice_pkg::OP_SUB, slice_pkg::OP_ADDSUB,
              slice_pkg::OP_GE, slice_pkg::OP_NE, slice_pkg::OP_LE};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 13; i++) begin
         apb(1'b0, (i == 12) ? 8'h40 : 8'(i / 3 * 16 + i % 3 * 4), '0, 1'b0);
         `CHECK("reset value", 32'h0, rd)
      end
      apb(1'b0, 8'h44, '0, 1'b1);
      apb(1'b0, 8'h06, '0, 1'b1);
      apb(1'b1, 8'h0c, 32'hff, 1'b1);
      $display("test registers done");
      for (k = 0; k < 4; k++) begin
         t0[k] = 16'($random(seed));
         t1[k] = 16'($random(seed));
         apb(1'b1, ra(k, slice_pkg::OFS_TABLE0), 32'(t0[k]), 1'b0);
         apb(1'b1, ra(k, slice_pkg::OFS_TABLE1), 32'(t1[k]), 1'b0);
      end
      apb(1'b1, slice_pkg::ADDR_USER, 32'h1, 1'b0);
      apb(1'b1, ra(1, slice_pkg::OFS_TABLE1), 32'h0, 1'b1);
      for (i = 0; i < 40; i++) begin
         r16 = 16'($random(seed));
         table_a <= r16;
         table_b <= r16;
         {sel5, sel6, sel7, slice_ce} <= 11'($random(seed));
         repeat (2) @(posedge clk);
         for (k = 0; k < 4; k++) begin
            x = lut(k, table_a[k]);
            `CHECK("table output", x, f[k])
            `CHECK("five-input", x[sel5[k]], f5[k])
         end
      end
      $display("test logic done");
      // slice 0 in ripple mode, each operation ten times
      for (i = 0; i < 60; i++) begin
         k = i / 10;
         if (i % 10 == 0) apb(1'b1, 8'h00, (32'(ops[k]) << 7) | 32'h1, 1'b0);
         {x, y} = 4'($random(seed));
         carry_in <= 1'($random(seed));
         sub_ctl <= 4'($random(seed));
         table_a[0] <= {2'h0, x};
         table_b[0] <= {2'h0, y};
         repeat (2) @(posedge clk);
         `CHECK("ripple result", rip(ops[k], x, y, carry_in), f[0])
         if (ops[k] == slice_pkg::OP_ADD) begin
            `CHECK("carry pair", {(3'(x) + 3'(y)) > 3'h3, &(x ^ y)},
                   {carry_gen[0], carry_prop[0]})
            // slices 1 to 3 stay in add and pass the carry on
            c = 3'(x) + 3'(y) + 3'(carry_in) > 3'h3;
            for (int j = 1; j < 4; j++)
               c = 3'(table_a[j][1:0]) + 3'(table_b[j][1:0]) + 3'(c) > 3'h3;
            `CHECK("carry out", c, carry_out)
         end
      end
      $display("test ripple done");
      apb(1'b1, ra(1, slice_pkg::OFS_CTRL), 32'h2, 1'b0);
      for (i = 0; i < 8; i++) begin
         {a, x} = 6'($random(seed));
         table_a[1] <= a;
         data_in[1] <= x;
         ram_we[1] <= (i % 4 != 3);
         pulse[1] <= 1'b1;
         @(posedge clk);
         pulse[1] <= 1'b0;
         repeat (3) @(posedge clk);
         ram_we[1] <= 1'b0;
         data_in[1] <= ~x;
         if (i % 4 != 3) {t1[1][a], t0[1][a]} = x;
         repeat (2) @(posedge clk);
         `CHECK("ram word", lut(1, a), f[1])
      end
      apb(1'b1, ra(3, slice_pkg::OFS_CTRL), 32'h3, 1'b0);
      {table_a[3], table_b[3], data_in[3], ram_we[3], pulse[3]} <= 12'h55f;
      repeat (6) @(posedge clk);
      {ram_we[3], pulse[3]} <= 2'h0;
      repeat (2) @(posedge clk);
      `CHECK("rom word", lut(3, 4'h5), f[3])
      $display("test memory done");
      apb(1'b1, 8'h40, 32'h0, 1'b0);
      apb(1'b1, ra(2, slice_pkg::OFS_CTRL), 32'h60, 1'b0);
      repeat (2) @(posedge clk);
      `CHECK("configured value", 2'h3, q[2])
      apb(1'b1, 8'h40, 32'h1, 1'b0);
      apb(1'b1, ra(2, slice_pkg::OFS_CTRL), 32'h30, 1'b0);
      slice_lsr[2] <= 1'b1;
      repeat (3) @(posedge clk);
      `CHECK("async set/reset", 2'h1, q[2])
      apb(1'b1, ra(2, slice_pkg::OFS_CTRL), 32'h40, 1'b0);
      repeat (3) @(posedge clk);
      `CHECK("sync waits for edge", 2'h1, q[2])
      pulse[2] <= 1'b1;
      @(posedge clk);
      pulse[2] <= 1'b0;
      repeat (3) @(posedge clk);
      `CHECK("sync set/reset", 2'h2, q[2])
      slice_lsr[2] <= 1'b0;
      slice_ce[2] <= 1'b1;
      {table_a[2], table_b[2]} <= 8'h99;
      apb(1'b1, ra(2, slice_pkg::OFS_CTRL), 32'hc, 1'b0);
      repeat (2) @(posedge clk);
      `CHECK("latch follows", lut(2, 4'h9), q[2])
      $display("test storage done");
      stop_test();
   end
endmodule // programmable_function_unit_bench
